/* File: hw/charger_cfg_pkg.sv */
// Package: register map, field layout, reset values and timing constants
package charger_cfg_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] KICK_REG_OFFSET  = 8'h03;
  localparam logic [7:0] VCHG_REG_OFFSET  = 8'h06;
  localparam logic [7:0] TMR_REG_OFFSET   = 8'h07;
  localparam logic [7:0] COMP_REG_OFFSET  = 8'h08;

  // ==========================================================
  // Reset values
  localparam logic [7:0] VCHG_REG_RESET   = 8'h82;
  localparam logic [7:0] TMR_REG_RESET    = 8'h9d;
  localparam logic [7:0] COMP_REG_RESET   = 8'h03;
  localparam logic [5:0] VCHG_CODE_MAX    = 6'h30;

  // ==========================================================
  // Field positions
  localparam int KICK_BIT      = 6;
  localparam int VCHG_MSB      = 7;
  localparam int VCHG_LSB      = 2;
  localparam int PRECHG_BIT    = 1;
  localparam int RECHG_BIT     = 0;
  localparam int TERM_EN_BIT   = 7;
  localparam int PIN_MUTE_BIT  = 6;
  localparam int WD_MSB        = 5;
  localparam int WD_LSB        = 4;
  localparam int TIMER_EN_BIT  = 3;
  localparam int FCT_MSB       = 2;
  localparam int FCT_LSB       = 1;
  localparam int RSVD_BIT      = 0;
  localparam int IRR_MSB       = 7;
  localparam int IRR_LSB       = 5;
  localparam int IRC_MSB       = 4;
  localparam int IRC_LSB       = 2;
  localparam int TRPT_MSB      = 1;
  localparam int TRPT_LSB      = 0;

  // ==========================================================
  // Decoded quantities
  localparam logic [12:0] VCHG_OFFSET_MV  = 13'h0f00;
  localparam logic [12:0] VCHG_STEP_MV    = 13'h0010;
  localparam logic [11:0] PRECHG_LOW_MV   = 12'haf0;
  localparam logic [11:0] PRECHG_HIGH_MV  = 12'hbb8;
  localparam logic [7:0]  RECHG_LOW_MV    = 8'h64;
  localparam logic [7:0]  RECHG_HIGH_MV   = 8'hc8;
  localparam logic [7:0]  IRR_STEP_MOHM   = 8'h14;
  localparam logic [7:0]  IRC_STEP_MV     = 8'h20;
  localparam logic [6:0]  TRPT_BASE_C     = 7'h3c;
  localparam logic [6:0]  TRPT_STEP_C     = 7'h14;
  localparam logic [4:0]  FCT_5_H         = 5'h05;
  localparam logic [4:0]  FCT_8_H         = 5'h08;
  localparam logic [4:0]  FCT_12_H        = 5'h0c;
  localparam logic [4:0]  FCT_20_H        = 5'h14;

  // ==========================================================
  // Watchdog timing
  localparam logic [7:0]  WD_40_S         = 8'h28;
  localparam logic [7:0]  WD_80_S         = 8'h50;
  localparam logic [7:0]  WD_160_S        = 8'ha0;
  localparam longint      CLK_HZ          = 64'h0000_0000_0131_2d00;
  localparam longint      WD_TICK_S       = 64'h1;
  localparam int          WD_TICK_CYCLES  = int'(CLK_HZ * WD_TICK_S);
  localparam logic [6:0]  I2C_ADDR_RESET  = 7'h35;

  // ==========================================================
  // Enumerations
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX   = 3'b001,
    ST_ACK  = 3'b010,
    ST_TX   = 3'b011,
    ST_MACK = 3'b100
  } i2c_state_type;

  typedef enum logic [1:0] {
    PH_ADDR = 2'b00,
    PH_PTR  = 2'b01,
    PH_DATA = 2'b10
  } i2c_phase_type;

  // Timeout in seconds, zero when disabled
  function automatic logic [7:0] wd_limit(input logic [1:0] sel);
    logic [7:0] lim;
    lim = 8'h00;
    unique case (sel)
      2'b00: lim = 8'h00;
      2'b01: lim = WD_40_S;
      2'b10: lim = WD_80_S;
      2'b11: lim = WD_160_S;
    endcase
    return lim;
  endfunction

endpackage

/* File: hw/charger_config_registers.sv */
// Charger configuration register bank with serial slave and watchdog
`timescale 1ns/1ps
module charger_config_registers
  import charger_cfg_pkg::*;
#(
  parameter int         TICK_CYCLES = WD_TICK_CYCLES,
  parameter logic [6:0] DEV_ADDR    = I2C_ADDR_RESET
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Serial bus pins
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // Charger state inputs
  input  wire logic        charge_status_active,
  input  wire logic        term_current_reached,
  input  wire logic        charging_active,
  // Status pin, open drain
  output logic             status_pin_out,
  output logic             status_pin_oe,
  // Charger control outputs
  output logic             terminate_charge,
  output logic             safety_timer_run,
  output logic             watchdog_expired,
  // Configuration fields
  output logic [5:0]       charge_voltage_code,
  output logic             precharge_exit_threshold,
  output logic             recharge_offset_select,
  output logic             termination_enable,
  output logic             status_pin_disable,
  output logic [1:0]       watchdog_period,
  output logic             safety_timer_enable,
  output logic [1:0]       fast_charge_time_limit,
  output logic             reserved_timer_bit,
  output logic [2:0]       ir_comp_resistance,
  output logic [2:0]       ir_comp_clamp,
  output logic [1:0]       thermal_regulation_point,
  // Decoded values
  output logic [12:0]      charge_voltage_mv,
  output logic [11:0]      precharge_exit_mv,
  output logic [7:0]       recharge_offset_mv,
  output logic [7:0]       watchdog_timeout_s,
  output logic [4:0]       fast_charge_hours,
  output logic [7:0]       ir_comp_mohm,
  output logic [7:0]       ir_comp_clamp_mv,
  output logic [6:0]       thermal_point_c
);

  typedef struct packed {
    i2c_state_type state;
    i2c_phase_type phase;
    logic [3:0]    bit_cnt;
    logic [7:0]    shift;
    logic [7:0]    ptr;
    logic          rd;
    logic          sda_oe;
    logic          scl_q;
    logic          sda_q;
    logic [7:0]    vchg_cfg;
    logic [7:0]    tmr_cfg;
    logic [7:0]    comp_cfg;
    logic          kick;
    logic          stat_oe;
  } bank_state_type;

  bank_state_type r_ff;
  bank_state_type nxt_r;
  logic           scl_rise;
  logic           scl_fall;
  logic           bus_start;
  logic           bus_stop;
  logic [7:0]     rd_data;

  watchdog_if wd ();

  host_watchdog #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_watchdog (
    .clk     (clk),
    .reset_n (reset_n),
    .wd      (wd)
  );

  assign wd.period = r_ff.tmr_cfg[WD_MSB:WD_LSB];
  assign wd.kick   = r_ff.kick;

  // ==========================================================
  // Bus events
  // Inputs are already synchronous, so one stage finds the edges
  assign scl_rise  = scl_in & ~r_ff.scl_q;
  assign scl_fall  = ~scl_in & r_ff.scl_q;
  assign bus_start = scl_in & r_ff.scl_q & ~sda_in & r_ff.sda_q;
  assign bus_stop  = scl_in & r_ff.scl_q & sda_in & ~r_ff.sda_q;

  // Unmapped offsets read as zero
  always_comb begin
    rd_data = 8'h00;
    unique case (r_ff.ptr)
      KICK_REG_OFFSET: rd_data = 8'h00 | (8'(r_ff.kick) << KICK_BIT);
      VCHG_REG_OFFSET: rd_data = r_ff.vchg_cfg;
      TMR_REG_OFFSET:  rd_data = r_ff.tmr_cfg;
      COMP_REG_OFFSET: rd_data = r_ff.comp_cfg;
      default:         rd_data = 8'h00;
    endcase
  end

  // ==========================================================
  // Slave state machine and register writes
  always_comb begin
    nxt_r       = r_ff;
    nxt_r.scl_q = scl_in;
    nxt_r.sda_q = sda_in;
    nxt_r.kick  = 1'b0;
    if (bus_start) begin
      nxt_r.state   = ST_RX;
      nxt_r.phase   = PH_ADDR;
      nxt_r.bit_cnt = 4'h0;
      nxt_r.sda_oe  = 1'b0;
    end else if (bus_stop) begin
      nxt_r.state  = ST_IDLE;
      nxt_r.sda_oe = 1'b0;
    end else begin
      unique case (r_ff.state)
        ST_IDLE: begin
          nxt_r.sda_oe = 1'b0;
        end
        ST_RX: begin
          if (scl_rise && r_ff.bit_cnt != 4'h8) begin
            nxt_r.shift   = {r_ff.shift[6:0], sda_in};
            nxt_r.bit_cnt = r_ff.bit_cnt + 4'h1;
          end else if (scl_fall && r_ff.bit_cnt == 4'h8) begin
            nxt_r.bit_cnt = 4'h0;
            nxt_r.state   = ST_ACK;
            nxt_r.sda_oe  = 1'b1;
            unique case (r_ff.phase)
              PH_ADDR: begin
                if (r_ff.shift[7:1] == DEV_ADDR) begin
                  nxt_r.rd    = r_ff.shift[0];
                  nxt_r.phase = PH_PTR;
                end else begin
                  nxt_r.state  = ST_IDLE;
                  nxt_r.sda_oe = 1'b0;
                end
              end
              PH_PTR: begin
                nxt_r.ptr   = r_ff.shift;
                nxt_r.phase = PH_DATA;
              end
              PH_DATA: begin
                nxt_r.ptr = r_ff.ptr + 8'h01;
                unique case (r_ff.ptr)
                  KICK_REG_OFFSET: begin
                    nxt_r.kick = r_ff.shift[KICK_BIT];
                  end
                  VCHG_REG_OFFSET: begin
                    nxt_r.vchg_cfg = r_ff.shift;
                    // Clamp keeps the limit at its top code
                    if (r_ff.shift[VCHG_MSB:VCHG_LSB] > VCHG_CODE_MAX)
                      nxt_r.vchg_cfg[VCHG_MSB:VCHG_LSB] = VCHG_CODE_MAX;
                  end
                  TMR_REG_OFFSET: begin
                    nxt_r.tmr_cfg = r_ff.shift;
                  end
                  COMP_REG_OFFSET: begin
                    nxt_r.comp_cfg = r_ff.shift;
                  end
                  default: begin
                    nxt_r.ptr = r_ff.ptr + 8'h01;
                  end
                endcase
              end
              default: begin
                nxt_r.state  = ST_IDLE;
                nxt_r.sda_oe = 1'b0;
              end
            endcase
          end
        end
        ST_ACK: begin
          if (scl_rise) begin
            nxt_r.bit_cnt = 4'h1;
          end else if (scl_fall && r_ff.bit_cnt == 4'h1) begin
            nxt_r.bit_cnt = 4'h0;
            if (r_ff.rd) begin
              nxt_r.shift  = rd_data;
              nxt_r.ptr    = r_ff.ptr + 8'h01;
              nxt_r.sda_oe = ~rd_data[7];
              nxt_r.state  = ST_TX;
            end else begin
              nxt_r.sda_oe = 1'b0;
              nxt_r.state  = ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (r_ff.bit_cnt == 4'h7) begin
              nxt_r.bit_cnt = 4'h0;
              nxt_r.sda_oe  = 1'b0;
              nxt_r.state   = ST_MACK;
            end else begin
              nxt_r.bit_cnt = r_ff.bit_cnt + 4'h1;
              nxt_r.shift   = {r_ff.shift[6:0], 1'b0};
              nxt_r.sda_oe  = ~r_ff.shift[6];
            end
          end
        end
        ST_MACK: begin
          // A not-acknowledge ends the read burst
          if (scl_rise) begin
            if (sda_in)
              nxt_r.state = ST_IDLE;
            else
              nxt_r.bit_cnt = 4'h1;
          end else if (scl_fall && r_ff.bit_cnt == 4'h1) begin
            nxt_r.bit_cnt = 4'h0;
            nxt_r.shift   = rd_data;
            nxt_r.ptr     = r_ff.ptr + 8'h01;
            nxt_r.sda_oe  = ~rd_data[7];
            nxt_r.state   = ST_TX;
          end
        end
        default: begin
          nxt_r.state  = ST_IDLE;
          nxt_r.sda_oe = 1'b0;
        end
      endcase
    end
    // Expiry beats a host write landing in the same cycle
    if (wd.expired) begin
      nxt_r.vchg_cfg = VCHG_REG_RESET;
      nxt_r.tmr_cfg  = TMR_REG_RESET;
      nxt_r.comp_cfg = COMP_REG_RESET;
    end
    nxt_r.stat_oe = charge_status_active & ~r_ff.tmr_cfg[PIN_MUTE_BIT];
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r_ff          <= '0;
      r_ff.state    <= ST_IDLE;
      r_ff.phase    <= PH_ADDR;
      r_ff.scl_q    <= 1'b1;
      r_ff.sda_q    <= 1'b1;
      r_ff.vchg_cfg <= VCHG_REG_RESET;
      r_ff.tmr_cfg  <= TMR_REG_RESET;
      r_ff.comp_cfg <= COMP_REG_RESET;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // ==========================================================
  // Outputs
  assign sda_out          = 1'b0;
  assign sda_oe           = r_ff.sda_oe;
  assign status_pin_out   = 1'b0;
  assign status_pin_oe    = r_ff.stat_oe;
  assign watchdog_expired = wd.expired;

  assign terminate_charge = term_current_reached &
                            r_ff.tmr_cfg[TERM_EN_BIT];
  assign safety_timer_run = charging_active &
                            r_ff.tmr_cfg[TIMER_EN_BIT];

  assign charge_voltage_code      = r_ff.vchg_cfg[VCHG_MSB:VCHG_LSB];
  assign precharge_exit_threshold = r_ff.vchg_cfg[PRECHG_BIT];
  assign recharge_offset_select   = r_ff.vchg_cfg[RECHG_BIT];
  assign termination_enable       = r_ff.tmr_cfg[TERM_EN_BIT];
  assign status_pin_disable       = r_ff.tmr_cfg[PIN_MUTE_BIT];
  assign watchdog_period          = r_ff.tmr_cfg[WD_MSB:WD_LSB];
  assign safety_timer_enable      = r_ff.tmr_cfg[TIMER_EN_BIT];
  assign fast_charge_time_limit   = r_ff.tmr_cfg[FCT_MSB:FCT_LSB];
  assign reserved_timer_bit       = r_ff.tmr_cfg[RSVD_BIT];
  assign ir_comp_resistance       = r_ff.comp_cfg[IRR_MSB:IRR_LSB];
  assign ir_comp_clamp            = r_ff.comp_cfg[IRC_MSB:IRC_LSB];
  assign thermal_regulation_point = r_ff.comp_cfg[TRPT_MSB:TRPT_LSB];

  assign charge_voltage_mv  = VCHG_OFFSET_MV +
                              13'(charge_voltage_code) * VCHG_STEP_MV;
  assign precharge_exit_mv  = precharge_exit_threshold ?
                              PRECHG_HIGH_MV : PRECHG_LOW_MV;
  assign recharge_offset_mv = recharge_offset_select ?
                              RECHG_HIGH_MV : RECHG_LOW_MV;
  assign watchdog_timeout_s = wd_limit(watchdog_period);
  assign ir_comp_mohm       = 8'(ir_comp_resistance) * IRR_STEP_MOHM;
  assign ir_comp_clamp_mv   = 8'(ir_comp_clamp) * IRC_STEP_MV;
  assign thermal_point_c    = TRPT_BASE_C + TRPT_STEP_C *
                              7'(thermal_regulation_point);

  always_comb begin
    fast_charge_hours = FCT_12_H;
    unique case (fast_charge_time_limit)
      2'b00: fast_charge_hours = FCT_5_H;
      2'b01: fast_charge_hours = FCT_8_H;
      2'b10: fast_charge_hours = FCT_12_H;
      2'b11: fast_charge_hours = FCT_20_H;
    endcase
  end

endmodule // charger_config_registers

/* File: hw/host_watchdog.sv */
// Host watchdog timer: one-second tick divider and seconds counter
`timescale 1ns/1ps
module host_watchdog
  import charger_cfg_pkg::*;
#(
  parameter int TICK_CYCLES = WD_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // Register bank side
  watchdog_if.timer wd
);

  localparam int TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("host_watchdog: TICK_CYCLES must be at least 2");
  end

  typedef struct packed {
    logic [TW-1:0] tick_cnt;
    logic [7:0]    sec_cnt;
    logic          expired;
  } wd_state_type;

  wd_state_type r_ff;
  wd_state_type nxt_r;
  logic [7:0]   limit;

  assign limit      = wd_limit(wd.period);
  assign wd.expired = r_ff.expired;

  // ==========================================================
  // Counting
  always_comb begin
    nxt_r         = r_ff;
    nxt_r.expired = 1'b0;
    // Kick or disable restarts from zero
    if (wd.kick || limit == 8'h00) begin
      nxt_r.tick_cnt = '0;
      nxt_r.sec_cnt  = 8'h00;
    end else if (r_ff.tick_cnt == TICK_LAST) begin
      nxt_r.tick_cnt = '0;
      if (r_ff.sec_cnt + 8'h01 >= limit) begin
        nxt_r.expired = 1'b1;
        nxt_r.sec_cnt = 8'h00;
      end else begin
        nxt_r.sec_cnt = r_ff.sec_cnt + 8'h01;
      end
    end else begin
      nxt_r.tick_cnt = r_ff.tick_cnt + TW'(1);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

endmodule // host_watchdog

/* File: hw/watchdog_if.sv */
// Interface: link between register bank and host watchdog timer
`timescale 1ns/1ps
interface watchdog_if;
  logic [1:0] period;
  logic       kick;
  logic       expired;

  modport owner (output period, output kick, input expired);
  modport timer (input period, input kick, output expired);
endinterface

/* File: tb/config_checker.sv */
// Checker: port-level assertions for the charger register bank
`timescale 1ns/1ps
module config_checker
  import charger_cfg_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // Charger state and control
  input wire logic        charge_status_active,
  input wire logic        term_current_reached,
  input wire logic        charging_active,
  input wire logic        status_pin_oe,
  input wire logic        terminate_charge,
  input wire logic        safety_timer_run,
  input wire logic        watchdog_expired,
  // Fields
  input wire logic [5:0]  charge_voltage_code,
  input wire logic        precharge_exit_threshold,
  input wire logic        recharge_offset_select,
  input wire logic        termination_enable,
  input wire logic        status_pin_disable,
  input wire logic [1:0]  watchdog_period,
  input wire logic        safety_timer_enable,
  input wire logic [1:0]  fast_charge_time_limit,
  input wire logic        reserved_timer_bit,
  input wire logic [2:0]  ir_comp_resistance,
  input wire logic [2:0]  ir_comp_clamp,
  input wire logic [1:0]  thermal_regulation_point,
  // Decodes
  input wire logic [12:0] charge_voltage_mv,
  input wire logic [11:0] precharge_exit_mv,
  input wire logic [7:0]  recharge_offset_mv,
  input wire logic [7:0]  watchdog_timeout_s,
  input wire logic [4:0]  fast_charge_hours,
  input wire logic [7:0]  ir_comp_mohm,
  input wire logic [7:0]  ir_comp_clamp_mv,
  input wire logic [6:0]  thermal_point_c
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ==========================================================
  // Decodes and gates
  a_vchg_decode: assert property (
    charge_voltage_mv == 13'h0f00 + {3'h0, charge_voltage_code, 4'h0})
    else $error("charge voltage decode wrong");
  a_vchg_clamp: assert property (charge_voltage_code <= 6'h30)
    else $error("charge voltage code above limit");
  a_precharge_level: assert property (
    precharge_exit_mv == (precharge_exit_threshold ? 12'hbb8 : 12'haf0))
    else $error("precharge level wrong");
  a_recharge_offset: assert property (
    recharge_offset_mv == (recharge_offset_select ? 8'hc8 : 8'h64))
    else $error("recharge offset wrong");
  a_term_gate: assert property (
    terminate_charge == (term_current_reached && termination_enable))
    else $error("termination gate wrong");
  a_status_drive: assert property (
    charge_status_active && !status_pin_disable |=> status_pin_oe)
    else $error("status pin not driven");
  a_status_quiet: assert property (
    !(charge_status_active && !status_pin_disable) |=> !status_pin_oe)
    else $error("status pin driven while off");
  a_wd_decode: assert property (
    watchdog_timeout_s == (watchdog_period == 2'h0 ? 8'h00 :
      watchdog_period == 2'h1 ? 8'h28 :
      watchdog_period == 2'h2 ? 8'h50 : 8'ha0))
    else $error("watchdog period decode wrong");
  a_timer_gate: assert property (
    safety_timer_run == (charging_active && safety_timer_enable))
    else $error("safety timer gate wrong");
  a_fct_decode: assert property (
    fast_charge_hours == (fast_charge_time_limit == 2'h0 ? 5'h05 :
      fast_charge_time_limit == 2'h1 ? 5'h08 :
      fast_charge_time_limit == 2'h2 ? 5'h0c : 5'h14))
    else $error("fast charge hours decode wrong");
  a_irr_decode: assert property (
    ir_comp_mohm == {5'h00, ir_comp_resistance} * 8'h14)
    else $error("compensation resistance decode wrong");
  a_clamp_decode: assert property (
    ir_comp_clamp_mv == {ir_comp_clamp, 5'h00})
    else $error("compensation clamp decode wrong");
  a_trpt_decode: assert property (
    thermal_point_c == 7'h3c + {5'h00, thermal_regulation_point} * 7'h14)
    else $error("thermal point decode wrong");
  // ==========================================================
  // Watchdog expiry
  a_wd_reload: assert property (watchdog_expired |=>
    {charge_voltage_code, precharge_exit_threshold,
     recharge_offset_select} == VCHG_REG_RESET &&
    {termination_enable, status_pin_disable, watchdog_period,
     safety_timer_enable, fast_charge_time_limit,
     reserved_timer_bit} == TMR_REG_RESET &&
    {ir_comp_resistance, ir_comp_clamp,
     thermal_regulation_point} == COMP_REG_RESET)
    else $error("expiry did not reload defaults");
  a_expiry_pulse: assert property (
    watchdog_expired |=> !watchdog_expired)
    else $error("expiry pulse longer than one cycle");
endmodule // config_checker

bind charger_config_registers config_checker u_checker (.*);

/* File: tb/i2c_host_model.sv */
// Host processor model: serial bus master with open-drain data line
`timescale 1ns/1ps
module i2c_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h35
) (
  // Clock
  input  wire logic clk,
  // Bus lines
  input  wire logic sda_oe,
  output logic      scl,
  output logic      sda
);
  logic pull;

  // Pull-up: a released line reads high, never the last value
  assign sda = ~(pull | sda_oe);

  initial begin
    scl  = 1'b1;
    pull = 1'b0;
  end

  // ==========================================================
  // Bit level
  // Three clocks a phase, so the slave sees every edge
  task automatic gap();
    repeat (3) @(posedge clk);
  endtask

  task automatic start();
    pull <= 1'b0;
    gap();
    scl <= 1'b1;
    gap();
    pull <= 1'b1;
    gap();
    scl <= 1'b0;
    gap();
  endtask

  task automatic stop();
    pull <= 1'b1;
    gap();
    scl <= 1'b1;
    gap();
    pull <= 1'b0;
    gap();
  endtask

  task automatic bit_out(input logic b);
    pull <= ~b;
    gap();
    scl <= 1'b1;
    gap();
    scl <= 1'b0;
    gap();
  endtask

  task automatic bit_in(output logic r);
    pull <= 1'b0;
    gap();
    scl <= 1'b1;
    gap();
    r = sda;
    scl <= 1'b0;
    gap();
  endtask

  // ==========================================================
  // Byte and transfer level
  task automatic byte_out(input logic [7:0] d, output logic ok);
    logic n;
    for (int i = 7; i >= 0; i--) begin
      bit_out(d[i]);
    end
    bit_in(n);
    ok = ~n;
  endtask

  task automatic write(input logic [7:0] a, input logic [7:0] d,
                       output logic ok);
    logic k1, k2, k3;
    start();
    byte_out({DEV_ADDR, 1'b0}, k1);
    byte_out(a, k2);
    byte_out(d, k3);
    stop();
    ok = k1 & k2 & k3;
  endtask

  // Single-byte read, ended by a not-acknowledge
  task automatic read(input logic [7:0] a, output logic [7:0] d,
                      output logic ok);
    logic k1, k2, k3;
    start();
    byte_out({DEV_ADDR, 1'b0}, k1);
    byte_out(a, k2);
    start();
    byte_out({DEV_ADDR, 1'b1}, k3);
    for (int i = 7; i >= 0; i--) begin
      bit_in(d[i]);
    end
    bit_out(1'b1);
    stop();
    ok = k1 & k2 & k3;
  endtask
endmodule // i2c_host_model

/* File: tb/testbench.sv */
// Testbench: register bank driven over the serial bus by a host model
`timescale 1ns/1ps
module testbench;
  import charger_cfg_pkg::*;
  // Short second: 40 s becomes 4000 clocks
  localparam int TICK = 100;
  logic        clk;
  logic        reset_n;
  logic        scl;
  logic        sda;
  logic        sda_oe;
  logic        sda_out;
  logic        status_pin_out;
  logic        chg_in;
  logic        status_pin_oe;
  logic        terminate_charge;
  logic        safety_timer_run;
  logic        watchdog_expired;
  logic [5:0]  charge_voltage_code;
  logic        reserved_timer_bit;
  logic [12:0] charge_voltage_mv;
  logic [11:0] precharge_exit_mv;
  logic [7:0]  recharge_offset_mv;
  logic [7:0]  watchdog_timeout_s;
  logic [4:0]  fast_charge_hours;
  logic [7:0]  ir_comp_mohm;
  logic [7:0]  ir_comp_clamp_mv;
  logic [6:0]  thermal_point_c;
  int          n_errors;
  int          n_compared;
  int          cycles;

  charger_config_registers #(.TICK_CYCLES(TICK)) dut (
    .clk, .reset_n, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe,
    .charge_status_active(chg_in), .term_current_reached(chg_in),
    .charging_active(chg_in), .status_pin_out, .status_pin_oe,
    .terminate_charge, .safety_timer_run, .watchdog_expired,
    .charge_voltage_code, .precharge_exit_threshold(),
    .recharge_offset_select(), .termination_enable(),
    .status_pin_disable(), .watchdog_period(), .safety_timer_enable(),
    .fast_charge_time_limit(), .reserved_timer_bit,
    .ir_comp_resistance(), .ir_comp_clamp(), .thermal_regulation_point(),
    .charge_voltage_mv, .precharge_exit_mv, .recharge_offset_mv,
    .watchdog_timeout_s, .fast_charge_hours, .ir_comp_mohm,
    .ir_comp_clamp_mv, .thermal_point_c
  );

  i2c_host_model #(.DEV_ADDR(I2C_ADDR_RESET)) host (
    .clk, .sda_oe, .scl, .sda
  );

  always #25 clk = ~clk;

  // ==========================================================
  // Helpers
  task automatic summarize();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    host.write(a, d, ok);
    chk("write ack", 16'h0001, 16'(ok));
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    host.read(a, d, ok);
    chk("read ack", 16'h0001, 16'(ok));
    chk($sformatf("reg %h", a), 16'(exp), 16'(d));
  endtask

  // Gated outputs: terminate, status pin, safety timer
  task automatic pins(input logic v, input logic [2:0] exp);
    chg_in <= v;
    repeat (3) @(posedge clk);
    #1;
    chk("gates", 16'(exp),
        16'({terminate_charge, status_pin_oe, safety_timer_run}));
    @(posedge clk);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    rd(8'h06, 8'h82);
    rd(8'h07, 8'h9d);
    rd(8'h08, 8'h03);
    pins(1'b0, 3'b000);
    pins(1'b1, 3'b111);
    chk("mv", 16'h1100, 16'(charge_voltage_mv));
    chk("wd s", 16'h0028, 16'(watchdog_timeout_s));
    chk("hours", 16'h000c, 16'(fast_charge_hours));
    chk("deg", 16'h0078, 16'(thermal_point_c));
    chk("pin lvl", 16'h0000, 16'({sda_out, status_pin_out}));
  endtask

  task automatic t_fields();
    wr(8'h07, 8'h62);
    rd(8'h07, 8'h62);
    pins(1'b1, 3'b000);
    chk("wd s", 16'h0050, 16'(watchdog_timeout_s));
    chk("hours", 16'h0008, 16'(fast_charge_hours));
    wr(8'h07, 8'h30);
    chk("wd s", 16'h00a0, 16'(watchdog_timeout_s));
    chk("hours", 16'h0005, 16'(fast_charge_hours));
    wr(8'h06, 8'hff);
    rd(8'h06, 8'hc3);
    chk("mv", 16'h1200, 16'(charge_voltage_mv));
    chk("pre", 16'h0bb8, 16'(precharge_exit_mv));
    chk("rechg", 16'h00c8, 16'(recharge_offset_mv));
    wr(8'h06, 8'h54);
    rd(8'h06, 8'h54);
    chk("mv", 16'h1050, 16'(charge_voltage_mv));
    chk("pre", 16'h0af0, 16'(precharge_exit_mv));
    chk("rechg", 16'h0064, 16'(recharge_offset_mv));
    wr(8'h08, 8'he6);
    rd(8'h08, 8'he6);
    chk("mohm", 16'h008c, 16'(ir_comp_mohm));
    chk("clamp", 16'h0020, 16'(ir_comp_clamp_mv));
    chk("deg", 16'h0064, 16'(thermal_point_c));
    // Unmapped offset reads as zero
    rd(8'h0a, 8'h00);
  endtask

  // Kick midway must push expiry a full period past the kick
  task automatic t_watchdog();
    int t0;
    wr(8'h07, 8'h8c);
    wr(8'h07, 8'h9c);
    repeat (2000) @(posedge clk);
    wr(8'h03, 8'h40);
    t0 = cycles;
    rd(8'h03, 8'h00);
    while (watchdog_expired !== 1'b1 && cycles - t0 < 6000) @(posedge clk);
    chk("expiry time", 16'h0001,
        16'(cycles - t0 >= 3800 && cycles - t0 <= 4100));
    repeat (2) @(posedge clk);
    #1;
    chk("code", 16'h0020, 16'(charge_voltage_code));
    chk("rsvd", 16'h0001, 16'(reserved_timer_bit));
    @(posedge clk);
    rd(8'h06, 8'h82);
    rd(8'h07, 8'h9d);
    rd(8'h08, 8'h03);
  endtask

  // ==========================================================
  // Run control
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_errors++;
      summarize();
    end
  end

  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    chg_in = 1'b1;
    n_errors = 0;
    n_compared = 0;
    cycles = 0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_fields();
    t_watchdog();
    summarize();
  end
endmodule // testbench
